// ---- logic/sms_params.svh ----
`ifndef SMS_PARAMS_SVH
`define SMS_PARAMS_SVH
// reference clock and serial clock ceilings
`define SMS_CLK_HZ 20000000
`define SMS_FAST_SCK_MAX_HZ 32000000
`define SMS_SLOW_SCK_MAX_HZ 8000000
// number of port instances and the one that runs fast
`define SMS_INSTANCES 5
`define SMS_FAST_ID 0
// byte framing
`define SMS_FILL_BYTE 8'hff
`define SMS_LAST_BIT 3'h7
`define SMS_FIRST_BIT 3'h7
`endif

// ---- logic/sms_pkg.sv ----
package sms_pkg;
	// one-hot sequencer states for main and sub operation; ST_SHIFT is main only, ST_SWAIT sub only
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_FETCH = 6'h02,
		ST_SHIFT = 6'h04,
		ST_STORE = 6'h08,
		ST_SWAIT = 6'h10,
		ST_END = 6'h20
	} sms_state_t;
endpackage

// ---- logic/sms_sub_link.sv ----
`timescale 1ns/100ps
`include "sms_params.svh"
// sub-mode shifter clocked by the external main's serial clock
module sms_sub_link (
	input logic sck,
	input logic cs_n,
	input logic lnk_rst,
	input logic cpol,
	input logic cpha,
	input logic mosi,
	input logic [7:0] buf0,
	input logic [7:0] buf1,
	output logic [7:0] rx_byte,
	output logic rx_tgl,
	output logic miso,
	output logic miso_oe
);
	// capture edge is rising on this clock for every mode
	wire cap_clk = sck ^ cpol ^ cpha;
	// frame state dies with the select, so no edge after the frame is needed
	wire frame_rst = cs_n | lnk_rst;
	logic [2:0] cnt_reg;
	logic [6:0] sh_reg;
	logic bsel_reg;
	logic [2:0] out_idx_reg;

	// bit counter, shift register and buffer select per frame
	always_ff @(posedge cap_clk or posedge frame_rst) begin
		if (frame_rst) begin
			cnt_reg <= 3'h0;
			sh_reg <= 7'h00;
			bsel_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg + 3'h1;
			sh_reg <= {sh_reg[5:0], mosi};
			if (cnt_reg == `SMS_LAST_BIT) begin
				bsel_reg <= ~bsel_reg;
			end
		end
	end

	// finished byte and its event toggle survive the frame end
	always_ff @(posedge cap_clk or posedge lnk_rst) begin
		if (lnk_rst) begin
			rx_byte <= 8'h00;
			rx_tgl <= 1'b0;
		end else if (!cs_n && cnt_reg == `SMS_LAST_BIT) begin
			rx_byte <= {sh_reg, mosi};
			rx_tgl <= ~rx_tgl;
		end
	end

	// launch on the edge opposite to capture
	always_ff @(negedge cap_clk or posedge frame_rst) begin
		if (frame_rst) begin
			out_idx_reg <= `SMS_FIRST_BIT; // R13
		end else begin
			out_idx_reg <= `SMS_FIRST_BIT - cnt_reg; // R13
		end
	end

	// buffers are refilled only after their byte is done, so reads are stable
	assign miso = bsel_reg ? buf1[out_idx_reg] : buf0[out_idx_reg];
	// drive only while selected
	assign miso_oe = ~cs_n; // R5
endmodule

// ---- logic/sms_port.sv ----
`timescale 1ns/100ps
`include "sms_params.svh"
// Notes on behaviour
// R1: main mode drives clock, main-out data, samples main-in, drives low select.
// R2: main serial clock at most 32 MHz on fast instance, 8 MHz elsewhere.
// R3: only one select output is active; extra selects are ordinary pins.
// R4: optional data/command line marks bytes as command (low) or data (high).
// R5: in sub mode data output drives the bus only while select is low.
// R6: every instance supports both main and sub operation.
// R7: clock idle level selectable; capture on rising or falling edge selectable.
// R8: controller disables other peripherals sharing the instance before use.
// R9: disabling keeps shared settings; controller reprograms all of them before use.
// R10: up to five instances, each with own pin choice and memory transfer.
// R11: data moves between port and RAM without processor help.
// R12: each port signal may go to any pin not occupied by another function.
// R13: polarity and phase give four modes; launch is opposite to capture.
module sms_port #(
	parameter int INSTANCE_ID = 0,
	parameter int AW = 16,
	parameter int LW = 8,
	parameter int NP = 16,
	parameter int PW = 4
) (
	input logic CLK,
	input logic RESET,
	input logic ENABLE,
	input logic MAIN_MODE,
	input logic CPOL,
	input logic CPHA,
	input logic [7:0] HALF_DIV,
	input logic [LW-1:0] CMD_COUNT,
	input logic [AW-1:0] TX_PTR,
	input logic [LW-1:0] TX_LEN,
	input logic [AW-1:0] RX_PTR,
	input logic [LW-1:0] RX_LEN,
	input logic START,
	output logic BUSY,
	output logic DONE,
	output logic [LW-1:0] XFER_COUNT,
	output logic MEM_REQ,
	output logic MEM_WE,
	output logic [AW-1:0] MEM_ADDR,
	output logic [7:0] MEM_WDATA,
	input logic [7:0] MEM_RDATA,
	input logic MEM_ACK,
	input logic [NP-1:0] PIN_IN,
	input logic [NP-1:0] PIN_BUSY,
	input logic [PW-1:0] SEL_SCK,
	input logic [PW-1:0] SEL_MOSI,
	input logic [PW-1:0] SEL_CS,
	input logic [PW-1:0] SEL_DCS,
	input logic [PW-1:0] SEL_MISO,
	input logic DCS_EN,
	output logic [NP-1:0] PIN_OUT,
	output logic [NP-1:0] PIN_OE,
	input logic S_SCK,
	input logic S_CS_N,
	input logic S_MOSI,
	output logic S_MISO,
	output logic S_MISO_OE
);
	localparam bit FAST_INST = (INSTANCE_ID == `SMS_FAST_ID); // R10
	localparam int MAX_HZ = FAST_INST ? `SMS_FAST_SCK_MAX_HZ : `SMS_SLOW_SCK_MAX_HZ;
	localparam int HALF_MIN_I = (`SMS_CLK_HZ + 2 * MAX_HZ - 1) / (2 * MAX_HZ);
	localparam logic [7:0] HALF_MIN = 8'(HALF_MIN_I);

	sms_pkg::sms_state_t state_reg;
	logic main_q, cpol_q, cpha_q;
	logic [7:0] half_q;
	logic [LW-1:0] cmd_q, tx_len_q, rx_len_q, total_q;
	logic [AW-1:0] tx_ptr_q, rx_ptr_q;
	logic [LW-1:0] idx_reg, fidx_reg;
	logic [7:0] sh_reg, rx_sh_reg, rx_hold_reg, buf0_reg, buf1_reg, half_cnt_reg;
	logic [2:0] bit_cnt_reg;
	logic lead_reg, sck_reg, mosi_reg, cs_n_reg, dcs_reg;
	logic [NP-1:0] pin_s1_reg, pin_s2_reg;
	logic rxt_s1_reg, rxt_s2_reg, rxt_s3_reg;
	logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
	logic rx_pend_reg, cs_end_reg, lnk_rst_reg;
	logic [7:0] lnk_rx_byte;
	logic lnk_rx_tgl;
	logic [NP-1:0] cs_hit;

	wire st_idle = (state_reg == sms_pkg::ST_IDLE);
	wire st_fetch = (state_reg == sms_pkg::ST_FETCH);
	wire st_shift = (state_reg == sms_pkg::ST_SHIFT);
	wire st_store = (state_reg == sms_pkg::ST_STORE);
	wire st_swait = (state_reg == sms_pkg::ST_SWAIT);
	wire st_end = (state_reg == sms_pkg::ST_END);
	wire start_ok = START && ENABLE && st_idle;
	wire miso_in = pin_s2_reg[SEL_MISO];
	wire rx_evt = rxt_s2_reg ^ rxt_s3_reg;
	wire cs_rise = cs_s2_reg && !cs_s3_reg;
	wire half_up = (half_cnt_reg <= 8'h01);
	wire fetch_fill = (fidx_reg >= tx_len_q);
	wire fetch_done = st_fetch && (fetch_fill || (MEM_REQ && MEM_ACK && !MEM_WE));
	wire [7:0] fetch_byte = fetch_fill ? `SMS_FILL_BYTE : MEM_RDATA;
	wire store_need = (idx_reg < rx_len_q);
	wire store_done = st_store && (!store_need || (MEM_REQ && MEM_ACK && MEM_WE));
	wire [LW-1:0] idx_inc = idx_reg + LW'(1);

	// link domain logic, reset from this domain by a constant-only async path
	sms_sub_link u_link (
		.sck(S_SCK),
		.cs_n(S_CS_N),
		.lnk_rst(lnk_rst_reg),
		.cpol(cpol_q),
		.cpha(cpha_q),
		.mosi(S_MOSI),
		.buf0(buf0_reg),
		.buf1(buf1_reg),
		.rx_byte(lnk_rx_byte),
		.rx_tgl(lnk_rx_tgl),
		.miso(S_MISO),
		.miso_oe(S_MISO_OE)
	);

	// two-stage synchronisers for pins, select and byte toggle
	always_ff @(posedge CLK) begin
		lnk_rst_reg <= RESET;
		pin_s1_reg <= PIN_IN;
		pin_s2_reg <= pin_s1_reg;
		rxt_s1_reg <= lnk_rx_tgl;
		rxt_s2_reg <= rxt_s1_reg;
		rxt_s3_reg <= rxt_s2_reg;
		cs_s1_reg <= S_CS_N;
		cs_s2_reg <= cs_s1_reg;
		cs_s3_reg <= cs_s2_reg;
	end

	// settings latch at start; a disable never touches them
	always_ff @(posedge CLK) begin
		if (RESET) begin
			main_q <= 1'b0;
			cpol_q <= 1'b0;
			cpha_q <= 1'b0;
			half_q <= HALF_MIN;
			cmd_q <= '0;
			tx_ptr_q <= '0;
			tx_len_q <= '0;
			rx_ptr_q <= '0;
			rx_len_q <= '0;
			total_q <= '0;
		end else if (start_ok) begin // R9
			main_q <= MAIN_MODE; // R6
			cpol_q <= CPOL; // R7
			cpha_q <= CPHA; // R7
			half_q <= (HALF_DIV < HALF_MIN) ? HALF_MIN : HALF_DIV; // R2
			cmd_q <= CMD_COUNT;
			tx_ptr_q <= TX_PTR;
			tx_len_q <= TX_LEN;
			rx_ptr_q <= RX_PTR;
			rx_len_q <= RX_LEN;
			total_q <= (TX_LEN > RX_LEN) ? TX_LEN : RX_LEN;
		end
	end

	// sticky link events; a new event beats the clear in ST_SWAIT, reset and start beat the event
	always_ff @(posedge CLK) begin
		if (RESET || start_ok) begin
			rx_pend_reg <= 1'b0;
			cs_end_reg <= 1'b0;
		end else begin
			rx_pend_reg <= rx_evt || (rx_pend_reg && !st_swait);
			cs_end_reg <= cs_end_reg || (cs_rise && !main_q);
		end
	end

	// memory port: one request held until acknowledged
	always_ff @(posedge CLK) begin
		if (RESET) begin
			MEM_REQ <= 1'b0;
			MEM_WE <= 1'b0;
			MEM_ADDR <= '0;
			MEM_WDATA <= 8'h00;
		end else if (MEM_REQ) begin
			if (MEM_ACK) begin
				MEM_REQ <= 1'b0;
				MEM_WE <= 1'b0;
			end
		end else if (st_fetch && !fetch_fill) begin
			MEM_REQ <= 1'b1; // R11
			MEM_ADDR <= tx_ptr_q + AW'(fidx_reg);
		end else if (st_store && store_need) begin
			MEM_REQ <= 1'b1; // R11
			MEM_WE <= 1'b1;
			MEM_ADDR <= rx_ptr_q + AW'(idx_reg);
			MEM_WDATA <= rx_hold_reg;
		end
	end

	// transfer sequencer, byte counters and main-mode serial outputs
	always_ff @(posedge CLK) begin
		if (RESET) begin
			state_reg <= sms_pkg::ST_IDLE;
			idx_reg <= '0;
			fidx_reg <= '0;
			sh_reg <= 8'h00;
			rx_sh_reg <= 8'h00;
			rx_hold_reg <= 8'h00;
			buf0_reg <= `SMS_FILL_BYTE;
			buf1_reg <= `SMS_FILL_BYTE;
			half_cnt_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			lead_reg <= 1'b1;
			sck_reg <= 1'b0;
			mosi_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			dcs_reg <= 1'b1;
			BUSY <= 1'b0;
			DONE <= 1'b0;
		end else if (!ENABLE && !st_idle) begin
			// abort keeps settings; state goes idle, busy drops and select and clock are released
			state_reg <= sms_pkg::ST_IDLE;
			cs_n_reg <= 1'b1;
			sck_reg <= cpol_q;
			BUSY <= 1'b0;
			DONE <= 1'b0;
		end else begin
			DONE <= 1'b0;
			case (state_reg)
				sms_pkg::ST_IDLE: begin
					sck_reg <= cpol_q; // R7
					if (start_ok) begin
						idx_reg <= '0;
						fidx_reg <= '0;
						BUSY <= 1'b1;
						cs_n_reg <= !MAIN_MODE; // R1 R3
						sck_reg <= CPOL; // R7
						state_reg <= sms_pkg::ST_FETCH;
					end
				end
				sms_pkg::ST_FETCH: begin
					if (fetch_done) begin
						fidx_reg <= fidx_reg + LW'(1);
						if (main_q) begin
							sh_reg <= fetch_byte;
							dcs_reg <= (idx_reg >= cmd_q); // R4
							if (!cpha_q) begin
								mosi_reg <= fetch_byte[7]; // R13
							end
							half_cnt_reg <= half_q;
							bit_cnt_reg <= 3'h0;
							lead_reg <= 1'b1;
							state_reg <= sms_pkg::ST_SHIFT;
						end else begin
							if (fidx_reg[0]) begin
								buf1_reg <= fetch_byte;
							end else begin
								buf0_reg <= fetch_byte;
							end
							// both buffers primed before the first frame edge
							state_reg <= (fidx_reg == '0) ? sms_pkg::ST_FETCH : sms_pkg::ST_SWAIT;
						end
					end
				end
				sms_pkg::ST_SHIFT: begin
					if (!half_up) begin
						half_cnt_reg <= half_cnt_reg - 8'h01; // R2
					end else if (lead_reg) begin
						half_cnt_reg <= half_q;
						lead_reg <= 1'b0;
						sck_reg <= ~cpol_q; // R1
						if (!cpha_q) begin
							rx_sh_reg <= {rx_sh_reg[6:0], miso_in}; // R13
						end else begin
							mosi_reg <= sh_reg[7]; // R13
						end
					end else begin
						half_cnt_reg <= half_q;
						lead_reg <= 1'b1;
						sck_reg <= cpol_q;
						sh_reg <= {sh_reg[6:0], 1'b0};
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
						if (cpha_q) begin
							rx_sh_reg <= {rx_sh_reg[6:0], miso_in}; // R13
						end else begin
							mosi_reg <= sh_reg[6]; // R13
						end
						if (bit_cnt_reg == `SMS_LAST_BIT) begin
							rx_hold_reg <= cpha_q ? {rx_sh_reg[6:0], miso_in} : rx_sh_reg;
							state_reg <= sms_pkg::ST_STORE;
						end
					end
				end
				sms_pkg::ST_STORE: begin
					if (store_done) begin
						idx_reg <= idx_inc;
						half_cnt_reg <= half_q;
						if (!main_q) begin
							// refill the buffer just emptied, two bytes ahead
							state_reg <= sms_pkg::ST_FETCH;
						end else if (idx_inc >= total_q) begin
							state_reg <= sms_pkg::ST_END;
						end else begin
							state_reg <= sms_pkg::ST_FETCH;
						end
					end
				end
				sms_pkg::ST_SWAIT: begin
					if (rx_pend_reg) begin
						rx_hold_reg <= lnk_rx_byte;
						state_reg <= sms_pkg::ST_STORE;
					end else if (cs_end_reg) begin
						half_cnt_reg <= 8'h01;
						state_reg <= sms_pkg::ST_END;
					end
				end
				sms_pkg::ST_END: begin
					// hold select low for one half period after the last byte is stored
					if (!half_up) begin
						half_cnt_reg <= half_cnt_reg - 8'h01;
					end else begin
						cs_n_reg <= 1'b1; // R1
						BUSY <= 1'b0;
						DONE <= 1'b1;
						state_reg <= sms_pkg::ST_IDLE;
					end
				end
				default: begin
					state_reg <= sms_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign XFER_COUNT = idx_reg;

	// pin routing: a pin taken by another function is not driven from the cycle after it is taken
	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++) begin : g_pin
			wire h_sck = (SEL_SCK == PW'(gi));
			wire h_mosi = (SEL_MOSI == PW'(gi));
			wire h_dcs = DCS_EN && (SEL_DCS == PW'(gi)); // R4
			assign cs_hit[gi] = (SEL_CS == PW'(gi)); // R3
			wire own = ENABLE && MAIN_MODE && !PIN_BUSY[gi];
			always_ff @(posedge CLK) begin
				if (RESET) begin
					PIN_OUT[gi] <= 1'b0;
					PIN_OE[gi] <= 1'b0;
				end else begin
					PIN_OE[gi] <= own && (h_sck || h_mosi || cs_hit[gi] || h_dcs); // R12
					if (h_sck) begin
						PIN_OUT[gi] <= sck_reg;
					end else if (h_mosi) begin
						PIN_OUT[gi] <= mosi_reg;
					end else if (cs_hit[gi]) begin
						PIN_OUT[gi] <= cs_n_reg;
					end else begin
						PIN_OUT[gi] <= dcs_reg;
					end
				end
			end
		end
	endgenerate

	// checks on the sequencer and the main-mode wires
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	sequence s_main_go;
		start_ok && MAIN_MODE;
	endsequence
	sequence s_cs_active;
		##1 !cs_n_reg ##1 st_fetch;
	endsequence
	property p_main_select;
		s_main_go |-> s_cs_active;
	endproperty
	a_main_select: assert property (p_main_select) else $error("select not driven low"); // R1
	property p_idle_select;
		st_idle && !$past(st_end) |-> cs_n_reg;
	endproperty
	a_idle_select: assert property (p_idle_select) else $error("select low while idle"); // R1
	property p_slow_half;
		!FAST_INST && st_shift && $changed(sck_reg) |=> $stable(sck_reg);
	endproperty
	a_slow_half: assert property (p_slow_half) else $error("serial clock too fast"); // R2
	property p_one_select;
		$onehot0(cs_hit & PIN_OE);
	endproperty
	a_one_select: assert property (p_one_select) else $error("more than one select pin"); // R3
	property p_dcs_level;
		st_shift |-> dcs_reg == (idx_reg >= cmd_q);
	endproperty
	a_dcs_level: assert property (p_dcs_level) else $error("data/command level wrong"); // R4
	property p_modes;
		(st_shift |-> main_q) and (st_swait |-> !main_q);
	endproperty
	a_modes: assert property (p_modes) else $error("state not matching mode"); // R6
	property p_idle_level;
		st_fetch && main_q |-> sck_reg == cpol_q;
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("clock idle level wrong"); // R7
	property p_mem_hold;
		MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE);
	endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped"); // R11
	property p_busy_pin;
		(PIN_OE & $past(PIN_BUSY)) == '0;
	endproperty
	a_busy_pin: assert property (p_busy_pin) else $error("occupied pin driven"); // R12
	property p_launch;
		st_shift && !cpha_q && $changed(sck_reg) && sck_reg != cpol_q |-> $stable(mosi_reg);
	endproperty
	a_launch: assert property (p_launch) else $error("data moved on capture edge"); // R13
endmodule

// ---- dv/sms_sub_dev.sv ----
`timescale 1ns/100ps
// behavioural sub device standing on the main-mode pins
module sms_sub_dev (
	input wire logic clk,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic dcs,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [15:0] tx,
	output logic miso,
	output logic [15:0] rx,
	output logic [1:0] dx,
	output int hp
);
	int k;
	int c;
	bit seen;
	logic sl;
	logic [15:0] txs;
	realtime t0;
	initial miso = 1'b1;
	// frame start: first bit stands before any clock edge
	always @(negedge cs_n) begin
		k = 0;
		t0 = $realtime;
		txs = tx;
		miso = tx[15];
		seen = 0;
		hp = 999;
	end
	// deselected line shows the inverse, not a stale bit
	always @(posedge cs_n) miso = ~miso;
	// capture on the mode's edge; a level move at the select fall is no edge
	always @(sck) if (!cs_n && $realtime > t0) begin
		if (sck ^ cpol ^ cpha) begin
			if (k % 8 == 0) dx[k / 8] = dcs;
			rx = {rx[14:0], mosi};
			k++;
		end else if (k < 16) begin
			miso = txs[15 - k];
		end
	end
	// shortest half period seen between two clock edges
	always @(posedge clk) begin
		if (!cs_n && sck !== sl) begin
			if (seen && c < hp) hp = c;
			seen = 1;
			c = 0;
		end
		c++;
		sl = sck;
	end
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
// main transfers in all modes, an abort, and one sub frame
module tb_top;
	logic clk = 0;
	logic rst = 1;
	logic en = 1;
	logic mm = 1;
	logic cpol = 0;
	logic cpha = 0;
	logic start = 0;
	logic dcs_en = 1;
	logic ack = 0;
	logic s_sck = 0;
	logic s_cs_n = 1;
	logic s_mosi = 0;
	logic [7:0] hd = 8'h03;
	logic [7:0] cc = 8'h01;
	logic [7:0] txl = 8'h01;
	logic [7:0] rxl = 8'h02;
	logic [7:0] rdata = 8'h00;
	logic [7:0] b;
	logic [15:0] tp = 16'h0010;
	logic [15:0] rp = 16'h0020;
	logic [15:0] pbusy = 16'h0000;
	logic [15:0] ptx = 16'h9a51;
	logic [7:0] mem [0:255];
	wire busy, done, req, we, s_miso, s_oe, miso_l;
	wire [7:0] xc, wd;
	wire [15:0] addr, pout, poe, prx;
	wire [1:0] pdx;
	int hp;
	int errors = 0;
	int checked = 0;
	int dones = 0;
	int n;
	// released lines fall back to their idle pull levels
	wire sck_l = poe[1] ? pout[1] : cpol;
	wire cs_l = poe[3] ? pout[3] : 1'b1;
	always #25 clk = ~clk;
	sms_port i_sms_port (.CLK(clk), .RESET(rst), .ENABLE(en), .MAIN_MODE(mm), .CPOL(cpol),
		.CPHA(cpha), .HALF_DIV(hd), .CMD_COUNT(cc), .TX_PTR(tp), .TX_LEN(txl), .RX_PTR(rp),
		.RX_LEN(rxl), .START(start), .BUSY(busy), .DONE(done), .XFER_COUNT(xc),
		.MEM_REQ(req), .MEM_WE(we), .MEM_ADDR(addr), .MEM_WDATA(wd), .MEM_RDATA(rdata),
		.MEM_ACK(ack), .PIN_IN({10'h000, miso_l, 5'h00}), .PIN_BUSY(pbusy),
		.SEL_SCK(4'h1), .SEL_MOSI(4'h2), .SEL_CS(4'h3), .SEL_DCS(4'h4), .SEL_MISO(4'h5),
		.DCS_EN(dcs_en), .PIN_OUT(pout), .PIN_OE(poe), .S_SCK(s_sck), .S_CS_N(s_cs_n),
		.S_MOSI(s_mosi), .S_MISO(s_miso), .S_MISO_OE(s_oe));
	sms_sub_dev i_sms_sub_dev (.clk(clk), .sck(sck_l), .cs_n(cs_l), .mosi(pout[2]),
		.dcs(pout[4]), .cpol(cpol), .cpha(cpha), .tx(ptx), .miso(miso_l), .rx(prx),
		.dx(pdx), .hp(hp));
	// byte ram: ack one cycle after a request shows, one access at a time
	always @(negedge clk) begin
		ack <= req && !ack;
		rdata <= mem[addr[7:0]];
		if (req && we && !ack) mem[addr[7:0]] <= wd;
	end
	always @(posedge clk) if (done) dones++;
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out;
		if (errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic pulse;
		start = 1;
		@(negedge clk);
		start = 0;
	endtask
	// bounded wait for the end-of-transfer pulse
	task automatic wait_done(input int lim);
		n = 0;
		while (done !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk("done", done, 1'b1);
	endtask
	task automatic run_main(input logic [1:0] m, input logic [7:0] h);
		{cpol, cpha} = m;
		hd = h;
		cc = {6'h00, m};
		mem[8'h10] = 8'hc3 + m;
		mem[8'h20] = 8'h00;
		mem[8'h21] = 8'h00;
		@(negedge clk);
		pulse();
		wait_done(400);
		chk("pin oe", poe, 16'h001e);
		chk("mosi", prx, {8'hc3 + m, 8'hff});
		chk("data cmd", pdx, {cc < 8'h02, cc < 8'h01});
		chk("count", xc, 16'h0002);
		chk("half", 16'(hp), (h == 8'h00) ? 16'h0001 : {8'h00, h});
		// pin register plus two sync flops: capture needs four cycles a half
		if (h > 8'h03) begin
			chk("rx0", mem[8'h20], ptx[15:8]);
			chk("rx1", mem[8'h21], ptx[7:0]);
		end
		@(negedge clk);
		chk("sck idle", pout[1], cpol);
		chk("cs idle", pout[3], 1'b1);
	endtask
	// sub frame as the external main, link clock only inside the frame
	task automatic sub_frame(input logic [7:0] mo, output logic [7:0] mi);
		s_cs_n = 0;
		#6;
		chk("miso oe", s_oe, 1'b1);
		for (int i = 7; i >= 0; i--) begin
			s_mosi = mo[i];
			#6;
			s_sck = 1;
			mi[i] = s_miso;
			#6;
			s_sck = 0;
		end
		#6;
		s_cs_n = 1;
		s_mosi = ~s_mosi;
		#1;
		chk("miso off", s_oe, 1'b0);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		close_out();
	end
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'h00;
		repeat (16) @(negedge clk);
		chk("reset oe", poe, 16'h0000);
		chk("reset miso oe", s_oe, 1'b0);
		rst = 0;
		@(negedge clk);
		// abort mid-frame with the data/command pin claimed elsewhere
		pbusy = 16'h0010;
		hd = 8'h06;
		txl = 8'h02;
		pulse();
		repeat (30) @(negedge clk);
		chk("busy pin", poe, 16'h000e);
		chk("busy", busy, 1'b1);
		n = dones;
		en = 0;
		repeat (3) @(negedge clk);
		chk("abort oe", poe, 16'h0000);
		repeat (40) @(negedge clk);
		chk("no done", 16'(dones), 16'(n));
		en = 1;
		pbusy = 16'h0000;
		txl = 8'h01;
		for (int m = 0; m < 4; m++)
			run_main(2'(m), 8'h04);
		run_main(2'b00, 8'h00);
		// sub mode: one byte each way
		mm = 0;
		{cpol, cpha} = 2'b00;
		tp = 16'h0040;
		rp = 16'h0050;
		mem[8'h40] = 8'ha5;
		rxl = 8'h01;
		@(negedge clk);
		pulse();
		repeat (10) @(negedge clk);
		chk("sub pins", poe, 16'h0000);
		sub_frame(8'h3c, b);
		chk("sub miso", b, 8'ha5);
		wait_done(100);
		@(negedge clk);
		chk("sub rx", mem[8'h50], 8'h3c);
		close_out();
	end
endmodule
